// *** src/fsc_pkg.sv ***
// fsc_pkg: constants shared by the flash security and margin command block.
// assumes a 16-bit parameter word array indexed by a 3-bit index, and a
// byte-addressed register port with 32-bit data words.
package fsc_pkg;

	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS   = 8'h00; // flash_status_reg
	localparam logic [7:0] OFS_INDEX    = 8'h04; // cmd_param_index
	localparam logic [7:0] OFS_PARAM    = 8'h08; // cmd_param_word at index
	localparam logic [7:0] OFS_SECURITY = 8'h0C; // security_config_reg
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10; // sticky event bits, read only
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h14; // write one to clear, write only
	localparam logic [7:0] OFS_IRQ_EN   = 8'h18; // event enables
	localparam logic [7:0] OFS_MARGIN   = 8'h1C; // margin level per block

	// ------------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------------
	localparam int ST_COMPLETE = 7; // cmd_complete_flag, write one launches
	localparam int ST_ACCESS   = 5; // access_error_flag, write one clears
	localparam int ST_PROTECT  = 4; // protect_violation_flag, write one clears
	localparam int ST_VERIFY   = 1; // verify_error_flag, read only
	localparam int ST_FATAL    = 0; // verify_fatal_flag, read only

	// security register fields
	localparam int SEC_BACKDOOR_ENABLE_FIELD_HI = 7; // backdoor_enable_field upper bit
	localparam int SEC_BACKDOOR_ENABLE_FIELD_LO = 6; // backdoor_enable_field lower bit
	localparam int SEC_SECURED  = 0; // live security state

	// interrupt event bits
	localparam int EV_DONE   = 0; // command finished
	localparam int EV_ACCESS = 1; // access error recorded
	localparam int EV_VERIFY = 2; // verify error recorded
	localparam int EV_WIDTH  = 3;

	// margin register fields
	localparam int MG_PBLK_LO = 0; // program block level, two bits
	localparam int MG_DBLK_LO = 4; // data block level, two bits

	// ------------------------------------------------------------------
	// command codes, required indices and values
	// ------------------------------------------------------------------
	localparam logic [7:0]  CMD_UNSECURE   = 8'h0B;
	localparam logic [7:0]  CMD_BACKDOOR   = 8'h0C;
	localparam logic [7:0]  CMD_USR_MARGIN = 8'h0D;
	localparam logic [2:0]  IDX_UNSECURE   = 3'h0;
	localparam logic [2:0]  IDX_BACKDOOR   = 3'h4;
	localparam logic [2:0]  IDX_USR_MARGIN = 3'h1;
	localparam logic [1:0]  BACKDOOR_ENABLE_FIELD_ON       = 2'h2;
	localparam logic [15:0] MARGIN_NORMAL  = 16'h0000;
	localparam logic [15:0] MARGIN_ERASED  = 16'h0001;
	localparam logic [15:0] MARGIN_PROGRAM = 16'h0002;
	localparam logic [22:0] KEY0_ADDR      = 23'h7FFF00;

	// block identifiers in global address [22:16], plain defaults
	localparam logic [6:0]  PBLK_ID        = 7'h7F;
	localparam logic [6:0]  DBLK_ID        = 7'h10;

	// reset values
	localparam logic [7:0]  STATUS_RST     = 8'h80;
	localparam logic [2:0]  EV_EN_RST      = 3'h0;

	// sequencer states
	typedef enum logic [2:0] {
		FSC_IDLE,
		FSC_CHECK,
		FSC_ERASE,
		FSC_KEY_RD,
		FSC_KEY_CMP
	} fsc_state_t;

endpackage : fsc_pkg

// *** src/fsc_cmd_seq.sv ***
// fsc_cmd_seq: unsecure, backdoor key and user margin command sequencer.
// assumes the flash array engine answers an erase request with a one-cycle
// done pulse and verify results, and that key reads return data one cycle
// after the address is presented. all inputs except the asynchronous reset are synchronous to clk.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

// Summary of operation
// [R1] unsecure code 0B needs index 000
// [R2] unsecure erases all, verifies, then unsecures
// [R3] failed verify sets verify flag, keeps security
// [R4] any protected region gives protection violation
// [R5] any error flag one, uncorrectable flag zero
// [R6] software writes nothing while unsecure runs
// [R7] clearing complete flag launches; set when done
// [R8] backdoor code 0C needs index 100
// [R9] backdoor runs only when key enable 10
// [R10] compare keys from 7F_FF00; all match unsecures
// [R11] mismatch locks backdoor out until reset
// [R12] software avoids running from key block
// [R13] margin code 0D needs index 001
// [R14] margin values 0,1,2 only, else error
// [R15] unknown block address gives access error
// [R16] margin applies to addressed block only
// [R17] mode not allowed gives access error
// [R18] launch errors start nothing, complete set again
module fsc_cmd_seq
	import fsc_pkg::*;
(
	input  wire logic        clk,            // 10 MHz
	input  wire logic        reset,          // asynchronous, active high
	input  wire logic        ce,             // clock enable, freezes all state
	input  wire logic [7:0]  addr,           // register byte address
	input  wire logic [31:0] wdata,          // register write data
	input  wire logic        wr,             // write strobe
	input  wire logic        rd,             // read strobe
	output logic      [31:0] rdata,          // read data, cycle after rd
	output logic             irq,            // level interrupt
	input  wire logic        mode_ok,        // current mode allows unsecure/margin
	input  wire logic        any_protect,    // some region of flash is protected
	input  wire logic [1:0]  backdoor_enable_field_cfg,      // backdoor_enable_field from config
	output logic             erase_req,      // pulse: erase and verify everything
	input  wire logic        erase_done,     // pulse: erase and verify finished
	input  wire logic        verify_err,     // with done: any error seen
	input  wire logic        verify_fatal,   // with done: uncorrectable error seen
	output logic      [22:0] key_addr,       // global address of stored key word
	input  wire logic [15:0] key_data,       // stored key word, one cycle later
	output logic             secured,        // security state
	output logic      [1:0]  margin_pblk,    // read margin, program block
	output logic      [1:0]  margin_dblk     // read margin, data block
);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	logic [15:0]    param [0:7];     // cmd_param_word array
	logic [2:0]     param_index;     // cmd_param_index
	logic           cmd_complete;    // cmd_complete_flag
	logic           access_err;      // access_error_flag
	logic           protect_viol;    // protect_violation_flag
	logic           verify_flag;     // verify_error_flag
	logic           fatal_flag;      // verify_fatal_flag
	logic           key_locked;      // backdoor mismatch lockout
	logic [1:0]     key_enable;      // captured backdoor_enable_field
	logic [1:0]     key_idx;         // key under comparison
	logic           key_mismatch;    // any key seen different
	logic [EV_WIDTH-1:0] ev_stat;    // sticky events
	logic [EV_WIDTH-1:0] ev_en;      // event enables
	fsc_state_t     state;           // sequencer state

	logic           wr_status;       // status write this cycle
	logic           launch;          // valid launch request
	logic           wr_allowed;      // writes accepted only when idle
	logic [7:0]     cmd_code;        // code byte of word zero
	logic [6:0]     blk_id;          // global address [22:16]
	logic           blk_valid;       // blk_id names a flash block
	logic           margin_valid;    // margin setting in range
	logic           launch_err;      // access error found at check
	logic           ev_done;         // command completion event
	logic           ev_access;       // access error event
	logic           ev_verify;       // verify error event
	logic [EV_WIDTH-1:0] ev_set;     // events gathered per bit

	// status, index and parameter writes land only when the sequencer is idle;
	// those writes during a run are dropped so a stray write cannot corrupt the command
	assign wr_allowed   = wr && cmd_complete;
	assign wr_status    = wr_allowed && (addr == OFS_STATUS);
	// launch only if the write also leaves no error flag standing
	assign launch       = wr_status && wdata[ST_COMPLETE]
	                      && (!access_err || wdata[ST_ACCESS])
	                      && (!protect_viol || wdata[ST_PROTECT]);
	assign cmd_code     = param[0][15:8];
	assign blk_id       = param[0][6:0];
	assign blk_valid    = (blk_id == PBLK_ID) || (blk_id == DBLK_ID);
	assign margin_valid = (param[1] == MARGIN_NORMAL) || (param[1] == MARGIN_ERASED)
	                      || (param[1] == MARGIN_PROGRAM); // [R14]

	// ------------------------------------------------------------------
	// launch checks
	// ------------------------------------------------------------------
	// errors are judged from the parameters held at launch, all at once
	always_comb begin
		launch_err = 1'b0;
		case (cmd_code)
			CMD_UNSECURE: launch_err = (param_index != IDX_UNSECURE) || !mode_ok; // [R1] [R17]
			CMD_BACKDOOR: begin
				launch_err = (param_index != IDX_BACKDOOR)        // [R8]
				             || (key_enable != BACKDOOR_ENABLE_FIELD_ON)          // [R9]
				             || key_locked;                       // [R11]
			end
			CMD_USR_MARGIN: begin
				launch_err = (param_index != IDX_USR_MARGIN)      // [R13]
				             || !mode_ok                          // [R17]
				             || !blk_valid                        // [R15]
				             || !margin_valid;                    // [R14]
			end
			default: launch_err = 1'b1; // code not handled by this sequencer
		endcase
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	// one state register; the flags and outputs it drives live below
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= FSC_IDLE;
		end else if (ce) begin
			case (state)
				FSC_IDLE: if (launch) state <= FSC_CHECK; // [R7]
				FSC_CHECK: begin
					if (launch_err) begin
						state <= FSC_IDLE; // [R18]
					end else if (cmd_code == CMD_UNSECURE && any_protect) begin
						state <= FSC_IDLE; // [R4]
					end else if (cmd_code == CMD_UNSECURE) begin
						state <= FSC_ERASE; // [R2]
					end else if (cmd_code == CMD_BACKDOOR) begin
						state <= FSC_KEY_RD; // [R10]
					end else begin
						state <= FSC_IDLE; // margin takes effect at once
					end
				end
				FSC_ERASE: if (erase_done) state <= FSC_IDLE;
				FSC_KEY_RD: state <= FSC_KEY_CMP;
				FSC_KEY_CMP: state <= (key_idx == 2'h3) ? FSC_IDLE : FSC_KEY_RD; // [R10]
				default: state <= FSC_IDLE;
			endcase
		end
	end

	// cleared by the launch, held clear until the command ends
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_complete <= STATUS_RST[ST_COMPLETE];
		end else if (ce) begin
			if (launch) begin
				cmd_complete <= 1'b0; // [R7]
			end else if (ev_done) begin
				cmd_complete <= 1'b1; // [R7] [R18]
			end
		end
	end

	// completion: every path back to idle ends the command
	assign ev_done = ((state == FSC_CHECK) && (launch_err || cmd_code != CMD_BACKDOOR
	                  && !(cmd_code == CMD_UNSECURE && !any_protect)))
	                 || ((state == FSC_ERASE) && erase_done)
	                 || ((state == FSC_KEY_CMP) && (key_idx == 2'h3));

	// access error: at check, or on a key mismatch at the last compare
	assign ev_access = ((state == FSC_CHECK) && launch_err)
	                   || ((state == FSC_KEY_CMP) && (key_idx == 2'h3)
	                       && (key_mismatch || key_data != param[4]));
	assign ev_verify = (state == FSC_ERASE) && erase_done && verify_err;

	// a hardware set in the same cycle as a software clear wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			access_err   <= STATUS_RST[ST_ACCESS];
			protect_viol <= STATUS_RST[ST_PROTECT];
		end else if (ce) begin
			if (ev_access) begin
				access_err <= 1'b1; // [R11] [R18]
			end else if (wr_status && wdata[ST_ACCESS]) begin
				access_err <= 1'b0;
			end
			if (state == FSC_CHECK && !launch_err && cmd_code == CMD_UNSECURE
			    && any_protect) begin
				protect_viol <= 1'b1; // [R4]
			end else if (wr_status && wdata[ST_PROTECT]) begin
				protect_viol <= 1'b0;
			end
		end
	end

	// verify flags are owned by hardware: cleared at launch, set by verify
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			verify_flag <= STATUS_RST[ST_VERIFY];
			fatal_flag  <= STATUS_RST[ST_FATAL];
		end else if (ce) begin
			if (launch) begin
				verify_flag <= 1'b0;
				fatal_flag  <= 1'b0;
			end else if (state == FSC_ERASE && erase_done) begin
				verify_flag <= verify_err;   // [R3] [R5]
				fatal_flag  <= verify_fatal; // [R5]
			end
		end
	end

	// ------------------------------------------------------------------
	// security state and lockout
	// ------------------------------------------------------------------
	// the device comes out of reset secured; only a clean erase or a full
	// key match releases it, and nothing here ever secures it again
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			secured    <= 1'b1;
			key_locked <= 1'b0;
		end else if (ce) begin
			if (state == FSC_ERASE && erase_done && !verify_err && !verify_fatal) begin
				secured <= 1'b0; // [R2] [R3]
			end
			if (state == FSC_KEY_CMP && key_idx == 2'h3) begin
				if (key_mismatch || key_data != param[4]) begin
					key_locked <= 1'b1; // [R11]
				end else begin
					secured <= 1'b0; // [R10]
				end
			end
		end
	end

	// the enable field is sampled every enabled cycle after reset release, never at reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			key_enable <= 2'h0;
		end else if (ce) begin
			key_enable <= backdoor_enable_field_cfg;
		end
	end

	// keys are read one word at a time so the key store needs one port;
	// the compare costs two cycles per key
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			key_idx      <= 2'h0;
			key_mismatch <= 1'b0;
			key_addr     <= KEY0_ADDR;
		end else if (ce) begin
			if (state == FSC_CHECK) begin
				key_idx      <= 2'h0;
				key_mismatch <= 1'b0;
				key_addr     <= KEY0_ADDR; // [R10]
			end else if (state == FSC_KEY_CMP) begin
				if (key_data != param[3'(key_idx) + 3'h1]) key_mismatch <= 1'b1; // [R10]
				key_idx  <= key_idx + 2'h1;
				key_addr <= key_addr + 23'h000002; // next 16-bit key word
			end
		end
	end

	// one pulse as the unsecure run starts; the engine does erase+verify
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			erase_req <= 1'b0;
		end else if (ce) begin
			erase_req <= (state == FSC_CHECK) && !launch_err
			             && (cmd_code == CMD_UNSECURE) && !any_protect; // [R2]
		end
	end

	// only the addressed block changes; the other keeps its level
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			margin_pblk <= MARGIN_NORMAL[1:0];
			margin_dblk <= MARGIN_NORMAL[1:0];
		end else if (ce) begin
			if (state == FSC_CHECK && !launch_err && cmd_code == CMD_USR_MARGIN) begin
				if (blk_id == PBLK_ID) begin
					margin_pblk <= param[1][1:0]; // [R16]
				end else begin
					margin_dblk <= param[1][1:0]; // [R16]
				end
			end
		end
	end

	// dropped while busy, so a run never sees its parameters move
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			param_index <= 3'h0;
		end else if (ce && wr_allowed && addr == OFS_INDEX) begin
			param_index <= wdata[2:0]; // [R6]
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_param
			// one word per index position
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					param[gi] <= 16'h0000;
				end else if (ce && wr_allowed && addr == OFS_PARAM
				             && param_index == 3'(gi)) begin
					param[gi] <= wdata[15:0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------------
	assign ev_set = {ev_verify, ev_access, ev_done};

	// sticky status; set wins over the clear register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ev_stat <= '0;
		end else if (ce) begin
			for (int i = 0; i < EV_WIDTH; i++) begin
				if (ev_set[i]) begin
					ev_stat[i] <= 1'b1;
				end else if (wr && addr == OFS_IRQ_CLR && wdata[i]) begin
					ev_stat[i] <= 1'b0;
				end
			end
		end
	end

	// enable register; interrupt control stays writable during a run
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ev_en <= EV_EN_RST;
		end else if (ce && wr && addr == OFS_IRQ_EN) begin
			ev_en <= wdata[EV_WIDTH-1:0];
		end
	end

	// registered level, one cycle behind the status bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(ev_stat & ev_en);
		end
	end

	// ------------------------------------------------------------------
	// read port
	// ------------------------------------------------------------------
	// data stand one cycle after rd and only then; unmapped reads give 0
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 32'h00000000;
		end else if (ce) begin
			rdata <= 32'h00000000;
			if (rd) begin
				case (addr)
					OFS_STATUS: begin
						rdata[ST_COMPLETE] <= cmd_complete;
						rdata[ST_ACCESS]   <= access_err;
						rdata[ST_PROTECT]  <= protect_viol;
						rdata[ST_VERIFY]   <= verify_flag;
						rdata[ST_FATAL]    <= fatal_flag;
					end
					OFS_INDEX: rdata[2:0] <= param_index;
					OFS_PARAM: rdata[15:0] <= param[param_index];
					OFS_SECURITY: begin
						rdata[SEC_BACKDOOR_ENABLE_FIELD_HI:SEC_BACKDOOR_ENABLE_FIELD_LO] <= key_enable;
						rdata[SEC_SECURED]               <= secured;
					end
					OFS_IRQ_STAT: rdata[EV_WIDTH-1:0] <= ev_stat;
					OFS_IRQ_EN: rdata[EV_WIDTH-1:0] <= ev_en;
					OFS_MARGIN: begin
						rdata[MG_PBLK_LO+1:MG_PBLK_LO] <= margin_pblk;
						rdata[MG_DBLK_LO+1:MG_DBLK_LO] <= margin_dblk;
					end
					default: rdata <= 32'h00000000; // clear register and holes read 0
				endcase
			end
		end
	end

endmodule : fsc_cmd_seq

// *** tb/fsc_cmd_seq_properties.sv ***
// fsc_cmd_seq_properties: port-level checks of the command sequencer.
// assumes one clock domain and that software never writes while busy.
`timescale 1ns/1ns
module fsc_cmd_seq_properties
	import fsc_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        mode_ok,
	input wire logic        any_protect,
	input wire logic        erase_req,
	input wire logic        erase_done,
	input wire logic        verify_err,
	input wire logic        verify_fatal,
	input wire logic [22:0] key_addr,
	input wire logic        secured
);
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	// a frozen clock enable holds every flop, so checks pause with it
	default disable iff (reset || !ce);
	logic launch_w; // status write that sets the complete bit
	assign launch_w = wr && addr == OFS_STATUS && wdata[ST_COMPLETE];
	sequence s_launch;
		launch_w;
	endsequence
	sequence s_pass;
		erase_done && !verify_err && !verify_fatal;
	endsequence
	sequence s_fail;
		erase_done && (verify_err || verify_fatal);
	endsequence
	// --------------------------------------------------------------
	// properties
	// --------------------------------------------------------------
	property p_erase_cause;
		$rose(erase_req) |-> $past(launch_w, 2);
	endproperty
	property p_erase_pulse;
		erase_req |=> !erase_req;
	endproperty
	property p_release;
		s_pass |=> !secured;
	endproperty
	property p_keep;
		s_fail |=> $stable(secured);
	endproperty
	property p_stay_open;
		!secured |=> !secured;
	endproperty
	property p_prot_no_erase;
		s_launch ##0 any_protect |-> ##2 !erase_req;
	endproperty
	property p_mode_no_erase;
		s_launch ##0 !mode_ok |-> ##2 !erase_req;
	endproperty
	property p_key_step;
		key_addr != $past(key_addr) |->
			key_addr == KEY0_ADDR || key_addr == $past(key_addr) + 23'h2;
	endproperty
	a_erase_cause : assert property (p_erase_cause) else $error("erase without launch");
	a_erase_pulse : assert property (p_erase_pulse) else $error("erase request too long");
	a_release : assert property (p_release) else $error("clean erase kept security");
	a_keep : assert property (p_keep) else $error("failed verify moved security");
	a_stay_open : assert property (p_stay_open) else $error("security came back");
	a_prot_no_erase : assert property (p_prot_no_erase) else $error("erase while protected");
	a_mode_no_erase : assert property (p_mode_no_erase) else $error("erase in wrong mode");
	a_key_step : assert property (p_key_step) else $error("key address out of order");
endmodule : fsc_cmd_seq_properties
bind fsc_cmd_seq fsc_cmd_seq_properties u_props (.clk(clk), .reset(reset), .ce(ce),
	.addr(addr), .wdata(wdata), .wr(wr), .mode_ok(mode_ok), .any_protect(any_protect),
	.erase_req(erase_req), .erase_done(erase_done), .verify_err(verify_err),
	.verify_fatal(verify_fatal), .key_addr(key_addr), .secured(secured));

// *** tb/fsc_flash_model.sv ***
// fsc_flash_model: flash array engine behind the sequencer.
// assumes erase requests are single pulses and key reads are registered.
`timescale 1ns/1ns
module fsc_flash_model
	import fsc_pkg::*;
#(
	parameter int          ERASE_CYC = 6,       // erase and verify length
	parameter logic [15:0] KEY_BASE  = 16'hC3A0 // stored key i is base plus i
)(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        erase_req,
	input  wire logic [1:0]  fail,       // bit0 any error, bit1 uncorrectable
	input  wire logic [22:0] key_addr,
	output logic             erase_done,
	output logic             verify_err,
	output logic             verify_fatal,
	output logic      [15:0] key_data
);
	int   cnt; // cycles left of an erase
	logic tg;  // junk pattern outside the done pulse
	// erase engine; results only mean something beside done
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt        <= 0;
			erase_done <= 1'b0;
			tg         <= 1'b0;
		end else begin
			tg         <= ~tg;
			erase_done <= cnt == 1;
			if (erase_req) cnt <= ERASE_CYC;
			else if (cnt != 0) cnt <= cnt - 1;
		end
	end
	assign verify_err   = erase_done ? fail[0] : tg;
	assign verify_fatal = erase_done ? fail[1] : ~tg;
	// key store, one cycle behind the address; junk off the key area
	always_ff @(posedge clk) begin
		if (key_addr[22:3] == KEY0_ADDR[22:3]) key_data <= KEY_BASE + 16'(key_addr[2:1]);
		else key_data <= ~key_data;
	end
endmodule : fsc_flash_model

// *** tb/flash_security_margin_commands_bench.sv ***
// flash_security_margin_commands_bench: self-checking bench of fsc_cmd_seq.
// assumes the flash model answers erase and key reads; ce is held high.
`timescale 1ns/1ns
module flash_security_margin_commands_bench
	import fsc_pkg::*;
;
	localparam logic [15:0] KB = 16'hC3A0; // stored key base
	typedef struct packed {
		logic [2:0] ix;
		logic [15:0] w0, w1;
		logic md, pr;
		logic [7:0] st, mg;
	} fsc_row_t;
	logic clk = 0, reset = 1, wr = 0, rd = 0, mode_ok = 1, any_protect = 0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [1:0]  backdoor_enable_field_cfg = 2'h1, fail = 2'h0, margin_pblk, margin_dblk;
	logic irq, erase_req, erase_done, verify_err, verify_fatal, secured;
	logic [22:0] key_addr;
	logic [15:0] key_data;
	logic [15:0] pw [5]; // parameter words to load
	int errors = 0, check_count = 0, cyc = 0;
	fsc_row_t rows [13] = '{
		'{3'h1, 16'h0D7F, 16'h0001, 1'b1, 1'b0, 8'h80, 8'h01},
		'{3'h1, 16'h0D10, 16'h0002, 1'b1, 1'b0, 8'h80, 8'h21},
		'{3'h1, 16'h0D7F, 16'h0002, 1'b1, 1'b0, 8'h80, 8'h22},
		'{3'h1, 16'h0D10, 16'h0000, 1'b1, 1'b0, 8'h80, 8'h02},
		'{3'h1, 16'h0D7F, 16'h0003, 1'b1, 1'b0, 8'hA0, 8'h02},
		'{3'h1, 16'h0D11, 16'h0001, 1'b1, 1'b0, 8'hA0, 8'h02},
		'{3'h0, 16'h0D7F, 16'h0001, 1'b1, 1'b0, 8'hA0, 8'h02},
		'{3'h1, 16'h0D7F, 16'h0000, 1'b0, 1'b0, 8'hA0, 8'h02},
		'{3'h1, 16'h0B00, 16'h0000, 1'b1, 1'b0, 8'hA0, 8'h02},
		'{3'h0, 16'h0B00, 16'h0000, 1'b0, 1'b0, 8'hA0, 8'h02},
		'{3'h0, 16'h0B00, 16'h0000, 1'b1, 1'b1, 8'h90, 8'h02},
		'{3'h3, 16'h0C00, 16'h0000, 1'b1, 1'b0, 8'hA0, 8'h02},
		'{3'h0, 16'h0E00, 16'h0000, 1'b1, 1'b0, 8'hA0, 8'h02}};
	always #50 clk = ~clk;
	fsc_cmd_seq dut_u (.clk(clk), .reset(reset), .ce(1'b1), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .mode_ok(mode_ok),
		.any_protect(any_protect), .backdoor_enable_field_cfg(backdoor_enable_field_cfg), .erase_req(erase_req),
		.erase_done(erase_done), .verify_err(verify_err), .verify_fatal(verify_fatal),
		.key_addr(key_addr), .key_data(key_data), .secured(secured),
		.margin_pblk(margin_pblk), .margin_dblk(margin_dblk));
	fsc_flash_model #(.KEY_BASE(KB)) u_flash (.clk(clk), .reset(reset),
		.erase_req(erase_req), .fail(fail), .key_addr(key_addr), .erase_done(erase_done),
		.verify_err(verify_err), .verify_fatal(verify_fatal), .key_data(key_data));
	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		if (errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bw
	task automatic br(input logic [7:0] a);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata; // data stand only in this cycle
	endtask : br
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		br(a);
		chk(nm, e, v);
	endtask : rchk
	// load n words, set the index, then launch and poll under a bound
	task automatic launch(input logic [2:0] ix, input int n);
		for (int i = 0; i < n; i++) begin
			bw(OFS_INDEX, 32'(i));
			bw(OFS_PARAM, {16'h0, pw[i]});
		end
		bw(OFS_INDEX, {29'h0, ix});
		bw(OFS_STATUS, 32'hB0); // old error flags cleared by the launch itself
		v = 32'h0;
		for (int k = 0; k < 200 && !v[ST_COMPLETE]; k++) br(OFS_STATUS);
	endtask : launch
	task automatic bkey(input logic [15:0] flip);
		pw[0] = 16'h0C00;
		for (int i = 1; i < 5; i++) pw[i] = KB + 16'(i - 1);
		pw[3] = pw[3] ^ flip; // a bad third key exercises the lockout
		launch(IDX_BACKDOOR, 5);
	endtask : bkey
	task automatic do_reset(input logic [1:0] k);
		reset     <= 1'b1;
		backdoor_enable_field_cfg <= k;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
	endtask : do_reset
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		do_reset(2'h1);
		rchk("status", OFS_STATUS, 32'h80);
		rchk("security", OFS_SECURITY, 32'h41);
		chk("irq", 32'h0, {31'h0, irq});
		bkey(16'h0);
		chk("status", 32'hA0, v);
		for (int f = 1; f >= 0; f--) begin
			@(posedge clk);
			fail <= f ? 2'h3 : 2'h0;
			pw[0] = 16'h0B00;
			launch(IDX_UNSECURE, 1);
			chk("status", f ? 32'h83 : 32'h80, v);
			chk("secured", 32'(f), {31'h0, secured});
		end
		do_reset(2'h2);
		@(posedge clk);
		fail <= 2'h1;
		launch(IDX_UNSECURE, 1);
		chk("status", 32'h82, v);
		chk("secured", 32'h1, {31'h0, secured});
		bkey(16'h0100);
		chk("status", 32'hA0, v);
		bkey(16'h0);
		chk("status", 32'hA0, v);
		chk("secured", 32'h1, {31'h0, secured});
		do_reset(2'h2);
		bkey(16'h0);
		chk("status", 32'h80, v);
		rchk("security", OFS_SECURITY, 32'h80);
		foreach (rows[i]) begin
			@(posedge clk);
			mode_ok     <= rows[i].md;
			any_protect <= rows[i].pr;
			pw[0] = rows[i].w0;
			pw[1] = rows[i].w1;
			launch(rows[i].ix, 2);
			chk("status", {24'h0, rows[i].st}, v);
			rchk("margin", OFS_MARGIN, {24'h0, rows[i].mg});
			chk("margin pins", {24'h0, rows[i].mg}, {26'h0, margin_dblk, 2'h0, margin_pblk});
		end
		chk("irq", 32'h0, {31'h0, irq});
		bw(OFS_IRQ_EN, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		bw(OFS_IRQ_CLR, 32'h7);
		repeat (2) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		rchk("irq status", OFS_IRQ_STAT, 32'h0);
		bw(8'h20, 32'hFFFFFFFF);
		rchk("unmapped", 8'h20, 32'h0);
		summarize();
	end
endmodule : flash_security_margin_commands_bench
